// ===== afs_pkg.sv
package afs_pkg;
  // Register offsets on the byte-wide register port.
  localparam logic [7:0] AFS_OFS_AGC_ONE   = 8'h1f;
  localparam logic [7:0] AFS_OFS_AGC_THREE = 8'h21;
  localparam logic [7:0] AFS_OFS_STRENGTH  = 8'h2c;
  localparam logic [7:0] AFS_OFS_RESULT    = 8'h3a;
  localparam logic [7:0] AFS_OFS_STS_EN    = 8'h4b;
  // Values after reset of the writable registers.
  localparam logic [7:0] AFS_RST_REG       = 8'h00;
  // Field positions in agc_control_one.
  localparam int AFS_B_GAIN_DISABLE = 0;
  localparam int AFS_B_HOLD_BIT     = 1;
  localparam int AFS_B_HOLD_SEL     = 2;
  localparam int AFS_F_HYST_LO      = 3;
  localparam int AFS_F_TIME_LO      = 5;
  // Field positions in the gain hold control and strength registers.
  localparam int AFS_F_HOLD_MODE_LO = 3;
  localparam int AFS_F_AVG_LO       = 0;
  localparam int AFS_F_CORR_LO      = 3;
  // Field positions in the status enable register.
  localparam int AFS_B_EN_STRENGTH  = 0;
  localparam int AFS_B_EN_STEP      = 1;
  localparam int AFS_B_EN_LOWGAIN   = 2;
  localparam int AFS_F_EN_TEST_LO   = 3;
  // Gain hold modes.
  localparam logic [1:0] AFS_HOLD_NOW      = 2'h0;
  localparam logic [1:0] AFS_HOLD_DEFER    = 2'h1;
  // Frame geometry and status positions.
  localparam int AFS_IQ_W     = 24;
  localparam int AFS_STS_W    = 16;
  localparam int AFS_FRAME_W  = 2 * AFS_IQ_W + AFS_STS_W;
  localparam int AFS_FIFO_D   = 32;
  localparam logic [5:0] AFS_STRENGTH_MAX = 6'h3f;
endpackage

// ===== afs_fifo.sv
`timescale 1ns/1ps
// Synchronous FIFO with valid and ready on both sides.
module afs_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  // Storage array; pointers carry one extra wrap bit.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_r;
  logic [AW:0]      wrPtr_nxt;
  logic [AW:0]      rdPtr_r;
  logic [AW:0]      rdPtr_nxt;
  logic             doWrite;
  logic             doRead;

  // Full when pointers differ only in the wrap bit.
  always_comb
  begin
    inReady   = (wrPtr_r ^ rdPtr_r) != {1'b1, {AW{1'b0}}};
    outValid  = wrPtr_r != rdPtr_r;
    doWrite   = inValid && inReady;
    doRead    = outValid && outReady;
    wrPtr_nxt = wrPtr_r + (AW + 1)'(doWrite);
    rdPtr_nxt = rdPtr_r + (AW + 1)'(doRead);
    outData   = mem[rdPtr_r[AW-1:0]];
  end

  // Pointer registers.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end
    else
    begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
    end
  end

  // The array is not reset; empty hides stale words.
  always_ff @(posedge core_clk)
  begin
    if (doWrite)
    begin
      mem[wrPtr_r[AW-1:0]] <= inData;
    end
  end
endmodule

// ===== afs_frame_status.sv
`timescale 1ns/1ps
// Summary of operation
// - Frame is 24 I, 24 Q, 16 status.
// - Status positions zero until enable set.
// - Test positions idle while enables cleared.
// - S9 shows front amplifier low gain.
// - Low gain shown in auto and manual.
// - S8 pulses on gain increase.
// - Step pulse lasts one sample period.
// - Mode 00 pulses at gain change.
// - Mode 01 pulses at hold rise if pending.
// - Mode 01 applies change at hold release.
// - S7 pulses on gain decrease.
// - Decrease follows increase timing.
// - S6 to S1 carry strength low bits.
// - Field spans -127 to -95.5 dBm.
// - Strength above range saturates to ones.
// - Strength updates only on new average.
module afs_frame_status
  import afs_pkg::*;
#(
  parameter int FIFO_DEPTH = afs_pkg::AFS_FIFO_D
) (
  input  wire logic                            core_clk,
  input  wire logic                            reset_n,
  input  wire logic [7:0]                      regAddr,
  input  wire logic [7:0]                      regWrData,
  input  wire logic                            regWrEn,
  output logic      [7:0]                      regRdData,
  input  wire logic                            sampleTick,
  input  wire logic [2*afs_pkg::AFS_IQ_W-1:0]  iqData,
  input  wire logic                            iqValid,
  output logic                                 iqReady,
  output logic      [afs_pkg::AFS_FRAME_W-1:0] frameData,
  output logic                                 frameLoad,
  input  wire logic                            frameReady,
  input  wire logic                            gainUpDetect,
  input  wire logic                            gainDownDetect,
  input  wire logic                            lowGainActive,
  input  wire logic [7:0]                      strengthCode,
  input  wire logic                            strengthValid,
  input  wire logic [4:0]                      testFlags,
  input  wire logic                            gain_hold_pin,
  output logic                                 applyGainUp,
  output logic                                 applyGainDown,
  output logic                                 auto_gain_disable,
  output logic      [2:0]                      auto_gain_time,
  output logic      [1:0]                      auto_gain_hysteresis,
  output logic      [2:0]                      strength_average_count,
  output logic      [1:0]                      strength_correction
);
  import afs_pkg::*;

  // Software-visible registers.
  logic [7:0] agcOne_r;
  logic [7:0] agcOne_nxt;
  logic [7:0] agcThree_r;
  logic [7:0] agcThree_nxt;
  logic [7:0] strengthCfg_r;
  logic [7:0] strengthCfg_nxt;
  logic [7:0] stsEnable_r;
  logic [7:0] stsEnable_nxt;
  logic [7:0] signal_strength_result_r;
  logic [7:0] signal_strength_result_nxt;

  // Gain hold tracking.
  logic       holdPrev_r;
  logic       holdPrev_nxt;
  logic       pendUp_r;
  logic       pendUp_nxt;
  logic       pendDown_r;
  logic       pendDown_nxt;
  logic       upLatch_r;
  logic       upLatch_nxt;
  logic       downLatch_r;
  logic       downLatch_nxt;
  logic       applyUp_r;
  logic       applyUp_nxt;
  logic       applyDown_r;
  logic       applyDown_nxt;

  // Per-frame snapshot and frame register.
  logic [AFS_STS_W-1:0]   statusSnap_r;
  logic [AFS_STS_W-1:0]   statusSnap_nxt;
  logic [AFS_FRAME_W-1:0] frame_r;
  logic [AFS_FRAME_W-1:0] frame_nxt;
  logic                   load_r;
  logic                   load_nxt;

  // Combinational helpers.
  logic                   holdLevel;
  logic                   holdRise;
  logic                   holdFall;
  logic                   deferMode;
  logic                   upEvent;
  logic                   downEvent;
  logic [5:0]             strengthField;
  logic [AFS_STS_W-1:0]   statusLive;
  logic [2*AFS_IQ_W-1:0]  fifoData;
  logic                   fifoValid;
  logic                   fifoPop;

  // Saturates the strength result into six bits rather than wrapping.
  function automatic logic [5:0] clamp6(input logic [7:0] code);
    if (code > {2'h0, AFS_STRENGTH_MAX})
    begin
      clamp6 = AFS_STRENGTH_MAX;
    end
    else
    begin
      clamp6 = code[5:0];
    end
  endfunction

  // Register writes and read mux; unmapped reads return zero.
  always_comb
  begin
    agcOne_nxt      = agcOne_r;
    agcThree_nxt    = agcThree_r;
    strengthCfg_nxt = strengthCfg_r;
    stsEnable_nxt   = stsEnable_r;
    if (regWrEn)
    begin
      case (regAddr)
        AFS_OFS_AGC_ONE:   agcOne_nxt      = regWrData;
        AFS_OFS_AGC_THREE: agcThree_nxt    = regWrData;
        AFS_OFS_STRENGTH:  strengthCfg_nxt = regWrData;
        AFS_OFS_STS_EN:    stsEnable_nxt   = regWrData;
        default:           agcOne_nxt      = agcOne_r;
      endcase
    end
    case (regAddr)
      AFS_OFS_AGC_ONE:   regRdData = agcOne_r;
      AFS_OFS_AGC_THREE: regRdData = agcThree_r;
      AFS_OFS_STRENGTH:  regRdData = strengthCfg_r;
      AFS_OFS_RESULT:    regRdData = signal_strength_result_r;
      AFS_OFS_STS_EN:    regRdData = stsEnable_r;
      default:           regRdData = 8'h00;
    endcase
    signal_strength_result_nxt = strengthValid ? strengthCode : signal_strength_result_r;
  end

  // Configuration fields are driven straight to the gain and strength engines.
  always_comb
  begin
    auto_gain_disable      = agcOne_r[AFS_B_GAIN_DISABLE];
    auto_gain_time         = agcOne_r[AFS_F_TIME_LO +: 3];
    auto_gain_hysteresis   = agcOne_r[AFS_F_HYST_LO +: 2];
    strength_average_count = strengthCfg_r[AFS_F_AVG_LO +: 3];
    strength_correction    = strengthCfg_r[AFS_F_CORR_LO +: 2];
  end

  // Register file storage.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      agcOne_r                 <= AFS_RST_REG;
      agcThree_r               <= AFS_RST_REG;
      strengthCfg_r            <= AFS_RST_REG;
      stsEnable_r              <= AFS_RST_REG;
      signal_strength_result_r <= AFS_RST_REG;
    end
    else
    begin
      agcOne_r                 <= agcOne_nxt;
      agcThree_r               <= agcThree_nxt;
      strengthCfg_r            <= strengthCfg_nxt;
      stsEnable_r              <= stsEnable_nxt;
      signal_strength_result_r <= signal_strength_result_nxt;
    end
  end

  // Gain step events. Only deferred mode holds a change back; the other
  // modes keep no gain, so they report and apply at once.
  always_comb
  begin
    holdLevel = agcOne_r[AFS_B_HOLD_SEL] ? agcOne_r[AFS_B_HOLD_BIT] : gain_hold_pin;
    holdRise  = holdLevel && !holdPrev_r;
    holdFall  = !holdLevel && holdPrev_r;
    deferMode = agcThree_r[AFS_F_HOLD_MODE_LO +: 2] == AFS_HOLD_DEFER;
    holdPrev_nxt = holdLevel;
    pendUp_nxt   = pendUp_r;
    pendDown_nxt = pendDown_r;
    applyUp_nxt   = 1'b0;
    applyDown_nxt = 1'b0;
    upEvent   = 1'b0;
    downEvent = 1'b0;
    if (deferMode)
    begin
      upEvent   = holdRise && pendUp_r;
      downEvent = holdRise && pendDown_r;
      if (holdFall)
      begin
        applyUp_nxt   = pendUp_r;
        applyDown_nxt = pendDown_r;
        pendUp_nxt    = 1'b0;
        pendDown_nxt  = 1'b0;
      end
      // A detection in the release cycle waits for the next hold cycle.
      if (gainUpDetect && !auto_gain_disable)
      begin
        pendUp_nxt = 1'b1;
      end
      if (gainDownDetect && !auto_gain_disable)
      begin
        pendDown_nxt = 1'b1;
      end
    end
    else
    begin
      upEvent       = gainUpDetect && !auto_gain_disable;
      downEvent     = gainDownDetect && !auto_gain_disable;
      applyUp_nxt   = upEvent;
      applyDown_nxt = downEvent;
      pendUp_nxt    = 1'b0;
      pendDown_nxt  = 1'b0;
    end
    // same timing both ways
    // Latches hold an event until the next sample; a new event wins the clear.
    upLatch_nxt   = (upLatch_r && !sampleTick) || upEvent;
    downLatch_nxt = (downLatch_r && !sampleTick) || downEvent;
    applyGainUp   = applyUp_r;
    applyGainDown = applyDown_r;
  end

  // Gain step storage.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      holdPrev_r  <= 1'b0;
      pendUp_r    <= 1'b0;
      pendDown_r  <= 1'b0;
      upLatch_r   <= 1'b0;
      downLatch_r <= 1'b0;
      applyUp_r   <= 1'b0;
      applyDown_r <= 1'b0;
    end
    else
    begin
      holdPrev_r  <= holdPrev_nxt;
      pendUp_r    <= pendUp_nxt;
      pendDown_r  <= pendDown_nxt;
      upLatch_r   <= upLatch_nxt;
      downLatch_r <= downLatch_nxt;
      applyUp_r   <= applyUp_nxt;
      applyDown_r <= applyDown_nxt;
    end
  end

  // Live status word, each position masked by its enable.
  always_comb
  begin
    strengthField = clamp6(signal_strength_result_r);
    statusLive    = '0;
    statusLive[0]     = testFlags[0] && stsEnable_r[AFS_F_EN_TEST_LO];
    statusLive[13:10] = testFlags[4:1] & stsEnable_r[AFS_F_EN_TEST_LO+1 +: 4];
    statusLive[9] = lowGainActive && stsEnable_r[AFS_B_EN_LOWGAIN];
    statusLive[8] = (upLatch_r || upEvent) && stsEnable_r[AFS_B_EN_STEP];
    statusLive[7] = (downLatch_r || downEvent) && stsEnable_r[AFS_B_EN_STEP];
    statusLive[6:1] = strengthField & {6{stsEnable_r[AFS_B_EN_STRENGTH]}};
  end

  // Sample cadence: the snapshot moves only on a sample tick, but the frame is built from the live status
  // word at the accepted tick; the step latches keep a flag until the next sample tick, accepted or not, and the snapshot feeds no output.
  always_comb
  begin
    statusSnap_nxt = sampleTick ? statusLive : statusSnap_r;
    fifoPop   = sampleTick && frameReady;
    frame_nxt = frame_r;
    load_nxt  = 1'b0;
    if (fifoPop && fifoValid)
    begin
      frame_nxt = {fifoData, statusLive};
      load_nxt  = 1'b1;
    end
    frameData = frame_r;
    frameLoad = load_r;
  end

  // Snapshot and frame storage.
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      statusSnap_r <= '0;
      frame_r      <= '0;
      load_r       <= 1'b0;
    end
    else
    begin
      statusSnap_r <= statusSnap_nxt;
      frame_r      <= frame_nxt;
      load_r       <= load_nxt;
    end
  end

  // Sample buffer; a stalled serializer backs up into iqReady.
  afs_fifo #(
    .WIDTH (2 * AFS_IQ_W),
    .DEPTH (FIFO_DEPTH)
  ) sampleBuf (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .inData   (iqData),
    .inValid  (iqValid),
    .inReady  (iqReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );
endmodule

// ===== afs_frame_status_checker.sv
`timescale 1ns/1ps
// Watches the frame, register and gain outputs of the status block.
module afs_frame_status_checker
  import afs_pkg::*;
(
  input wire logic                   core_clk,
  input wire logic                   reset_n,
  input wire logic [7:0]             regAddr,
  input wire logic [7:0]             regWrData,
  input wire logic                   regWrEn,
  input wire logic [7:0]             regRdData,
  input wire logic                   sampleTick,
  input wire logic [AFS_FRAME_W-1:0] frameData,
  input wire logic                   frameLoad,
  input wire logic                   frameReady,
  input wire logic                   lowGainActive,
  input wire logic [4:0]             testFlags,
  input wire logic                   applyGainUp,
  input wire logic                   applyGainDown
);
  // All checks share the core clock and its reset.
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // The top two status bits are unused.
  property p_top_zero; frameLoad |-> frameData[15:14] == 2'h0; endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("unused status bits set");
  // A frame only follows an accepted tick.
  property p_load_cause; frameLoad |-> $past(sampleTick && frameReady); endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("frame loaded without tick");
  // A frame holds until the next load.
  property p_hold_data; !frameLoad |-> $stable(frameData); endproperty
  a_hold_data: assert property (p_hold_data)
    else $error("frame changed between loads");
  // A raise pulse is one cycle long.
  property p_up_pulse; $rose(applyGainUp) |=> !applyGainUp; endproperty
  a_up_pulse: assert property (p_up_pulse)
    else $error("raise pulse too long");
  // A lower pulse is one cycle long.
  property p_down_pulse; $rose(applyGainDown) |=> !applyGainDown; endproperty
  a_down_pulse: assert property (p_down_pulse)
    else $error("lower pulse too long");
  // Remembers whether software ever enabled a test position.
  logic testEnSeen_r;
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      testEnSeen_r <= 1'b0;
    end
    else if (regWrEn && regAddr == AFS_OFS_STS_EN && regWrData[AFS_F_EN_TEST_LO +: 5] != 5'h00)
    begin
      testEnSeen_r <= 1'b1;
    end
  end
  // Busy test sources stay hidden while their enables are clear.
  property p_test_idle;
    frameLoad && !testEnSeen_r && $past(testFlags) != 5'h00
      |-> frameData[13:10] == 4'h0 && !frameData[0];
  endproperty
  a_test_idle: assert property (p_test_idle)
    else $error("test position active");
  // No low gain flag without low gain.
  property p_low_gain; frameLoad && !$past(lowGainActive) |-> !frameData[9]; endproperty
  a_low_gain: assert property (p_low_gain)
    else $error("low gain flag without cause");
  // The enable register reads back what was written.
  property p_reg_write;
    regWrEn && regAddr == AFS_OFS_STS_EN ##1 regAddr == AFS_OFS_STS_EN
      |-> regRdData == $past(regWrData);
  endproperty
  a_reg_write: assert property (p_reg_write)
    else $error("enable register readback wrong");
endmodule

bind afs_frame_status afs_frame_status_checker u_chk (
  .core_clk, .reset_n, .regAddr, .regWrData, .regWrEn, .regRdData, .sampleTick,
  .frameData, .frameLoad, .frameReady, .lowGainActive, .testFlags, .applyGainUp,
  .applyGainDown
);

// ===== afs_frame_sink.sv
`timescale 1ns/1ps
// Far-side receiver: takes each loaded frame and may stall.
module afs_frame_sink
  import afs_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic [AFS_FRAME_W-1:0] frameData,
  input  wire logic                   frameLoad,
  input  wire logic                   stall,
  output logic                        frameReady,
  output logic      [AFS_FRAME_W-1:0] lastFrame,
  output int                          frameCount
);
  // Ready drops while the bench asks for a slow receiver.
  assign frameReady = !stall;
  // whole frame taken
  // Each 64-bit frame is taken in one piece and counted.
  always_ff @(posedge core_clk or negedge reset_n)
    if (!reset_n)
    begin
      lastFrame  <= '0;
      frameCount <= 0;
    end
    else if (frameLoad)
    begin
      lastFrame  <= frameData;
      frameCount <= frameCount + 1;
    end
endmodule

// ===== test_adc_frame_status_flags.sv
`timescale 1ns/1ps
// Drives the status block with random and corner traffic.
module test_adc_frame_status_flags;
  import afs_pkg::*;
  logic        core_clk, reset_n, regWrEn, sampleTick, iqValid, iqReady, frameLoad;
  logic        frameReady, gainUpDetect, gainDownDetect, lowGainActive, strengthValid;
  logic        gain_hold_pin, applyGainUp, applyGainDown, stall, gainOff;
  logic [2:0]  gainTime, avgCount;
  logic [1:0]  gainHys, corrSel;
  // Strength codes around the saturation point and the bottom of the field.
  localparam logic [7:0] CORNER_CODES [4] = '{8'h3f, 8'h40, 8'hff, 8'h00};
  logic [7:0]  regAddr, regWrData, regRdData, strengthCode, en, sc;
  logic [4:0]  testFlags;
  logic [47:0] iqData, q[$];
  logic [63:0] frameData, lastFrame;
  int          frameCount, mismatches, check_count, seed, hit;
  afs_frame_status u_afs_frame_status (
    .core_clk, .reset_n, .regAddr, .regWrData, .regWrEn, .regRdData, .sampleTick,
    .iqData, .iqValid, .iqReady, .frameData, .frameLoad, .frameReady, .gainUpDetect,
    .gainDownDetect, .lowGainActive, .strengthCode, .strengthValid, .testFlags,
    .gain_hold_pin, .applyGainUp, .applyGainDown, .auto_gain_disable(gainOff),
    .auto_gain_time(gainTime), .auto_gain_hysteresis(gainHys),
    .strength_average_count(avgCount), .strength_correction(corrSel)
  );
  afs_frame_sink u_afs_frame_sink (
    .core_clk, .reset_n, .frameData, .frameLoad, .stall, .frameReady, .lastFrame,
    .frameCount
  );
  // Free-running core clock.
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [63:0] ex, input logic [63:0] got);
    check_count++;
    if (got !== ex)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask
  // Expected status word; masked positions stay zero.
  function automatic logic [15:0] expSts(input logic up, input logic dn);
    logic [15:0] s;
    s = 16'h0000;
    if (en[2]) s[9] = lowGainActive;
    if (en[1]) s[8:7] = {up, dn};
    if (en[0]) s[6:1] = (sc > 8'h3f) ? AFS_STRENGTH_MAX : sc[5:0];
    return s;
  endfunction
  // One register write, strobe held for one edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= v;
    regWrEn <= 1'b1;
    @(posedge core_clk);
    regWrEn <= 1'b0;
  endtask
  // Reads are combinational, so check just after the address settles.
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    @(posedge core_clk);
    regAddr <= a;
    #1 chk("register", 64'(ex), 64'(regRdData));
  endtask
  // Pushes n random samples back to back and queues them.
  task automatic push(input int n);
    logic [47:0] d;
    repeat (n)
    begin
      @(posedge core_clk);
      d = 48'({$random(seed), $random(seed)});
      iqData <= d;
      iqValid <= 1'b1;
      q.push_back(d);
    end
    @(posedge core_clk);
    iqValid <= 1'b0;
  endtask
  // Issues one sample tick and checks the frame, or its absence.
  task automatic tick(input bit want, input logic [15:0] st);
    int c0;
    c0 = frameCount;
    @(posedge core_clk);
    sampleTick <= 1'b1;
    @(posedge core_clk);
    sampleTick <= 1'b0;
    for (int i = 0; i < 4 && frameCount == c0; i++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (want && frameCount == c0)
    begin
      mismatches++;
      tally_and_finish();
    end
    if (want)
      chk("frame", {q.pop_front(), st}, lastFrame);
    else
      chk("frame count", 64'(c0), 64'(frameCount));
  endtask
  // New averaged strength result.
  task automatic setStr(input logic [7:0] c);
    @(posedge core_clk);
    strengthCode <= c;
    strengthValid <= 1'b1;
    @(posedge core_clk);
    strengthValid <= 1'b0;
    sc = c;
  endtask
  // One gain detect pulse; the apply pulse is checked one cycle on.
  task automatic step(input logic up, input logic ap);
    @(posedge core_clk);
    gainUpDetect <= up;
    gainDownDetect <= !up;
    @(posedge core_clk);
    gainUpDetect <= 1'b0;
    gainDownDetect <= 1'b0;
    #1 chk("apply", 64'({ap & up, ap & !up}), 64'({applyGainUp, applyGainDown}));
  endtask
  // Waits a bounded time for a deferred apply pulse.
  task automatic waitApply(input logic up);
    hit = 0;
    for (int i = 0; i < 8 && hit == 0; i++)
    begin
      @(posedge core_clk);
      #1 hit = up ? int'(applyGainUp) : int'(applyGainDown);
    end
    chk("deferred apply", 64'h1, 64'(hit));
    // A missing pulse ends the run rather than stalling later scenarios.
    if (hit == 0)
      tally_and_finish();
  endtask
  // Main sequence.
  initial
  begin
    {regAddr, regWrData, regWrEn, sampleTick, iqData, iqValid, gainUpDetect} = '0;
    {gainDownDetect, lowGainActive, strengthCode, strengthValid, testFlags} = '0;
    {gain_hold_pin, stall, en, sc} = '0;
    seed = 96;
    reset_n = 1'b0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(AFS_OFS_AGC_ONE, 8'h00);
    rd(AFS_OFS_AGC_THREE, 8'h00);
    rd(AFS_OFS_STRENGTH, 8'h00);
    rd(AFS_OFS_STS_EN, 8'h00);
    wr(AFS_OFS_RESULT, 8'h55);
    rd(AFS_OFS_RESULT, 8'h00);
    wr(AFS_OFS_AGC_ONE, 8'hf8);
    rd(AFS_OFS_AGC_ONE, 8'hf8);
    chk("gain fields", 64'h1f, 64'({gainOff, gainTime, gainHys}));
    wr(AFS_OFS_STRENGTH, 8'h1d);
    rd(AFS_OFS_STRENGTH, 8'h1d);
    chk("strength fields", 64'h17, 64'({avgCount, corrSel}));
    wr(AFS_OFS_AGC_ONE, 8'h00);
    lowGainActive <= 1'b1;
    // Test sources are kept busy so that masking is really exercised.
    testFlags <= 5'($random(seed)) | 5'h01;
    setStr(8'h2a);
    push(1);
    tick(1, expSts(0, 0));
    en = 8'h07;
    wr(AFS_OFS_STS_EN, en);
    rd(AFS_OFS_RESULT, 8'h2a);
    for (int i = 0; i < 6; i++)
    begin
      lowGainActive <= 1'($random(seed));
      setStr(i < 4 ? CORNER_CODES[i] : 8'($random(seed)));
      push(1);
      tick(1, expSts(0, 0));
    end
    strengthCode <= 8'h11;
    push(1);
    tick(1, expSts(0, 0));
    for (int up = 1; up >= 0; up--)
    begin
      step(1'(up), 1'b1);
      push(1);
      tick(1, expSts(1'(up), 1'(!up)));
      push(1);
      tick(1, expSts(0, 0));
    end
    wr(AFS_OFS_AGC_THREE, {3'h0, AFS_HOLD_DEFER, 3'h0});
    step(1'b1, 1'b0);
    push(1);
    tick(1, expSts(0, 0));
    gain_hold_pin <= 1'b1;
    push(1);
    tick(1, expSts(1, 0));
    gain_hold_pin <= 1'b0;
    waitApply(1'b1);
    wr(AFS_OFS_AGC_ONE, 8'h04);
    step(1'b0, 1'b0);
    wr(AFS_OFS_AGC_ONE, 8'h06);
    push(1);
    tick(1, expSts(0, 1));
    wr(AFS_OFS_AGC_ONE, 8'h04);
    waitApply(1'b0);
    // Hold mode 1x keeps nothing back, so it reports like mode 00.
    wr(AFS_OFS_AGC_THREE, 8'h10);
    step(1'b1, 1'b1);
    push(1);
    tick(1, expSts(1, 0));
    // Manual gain: detections are ignored, no pulse and no flag.
    wr(AFS_OFS_AGC_ONE, 8'h01);
    step(1'b0, 1'b0);
    chk("gain off", 64'h1, 64'(gainOff));
    push(1);
    tick(1, expSts(0, 0));
    stall <= 1'b1;
    push(AFS_FIFO_D);
    #1 chk("ready when full", 64'h0, 64'(iqReady));
    tick(0, 16'h0000);
    for (int i = 0; i < AFS_FIFO_D; i++)
    begin
      // A stalled tick must leave the buffered sample in place.
      if (1'($random(seed)))
      begin
        stall <= 1'b1;
        tick(0, 16'h0000);
      end
      stall <= 1'b0;
      tick(1, expSts(0, 0));
    end
    tick(0, 16'h0000);
    chk("ready when empty", 64'h1, 64'(iqReady));
    tally_and_finish();
  end
endmodule
